// file: hw/svdm_policy_fsm.sv
// structured message sequencer: port initiator and cable plug responder
`timescale 1ns/1ps
`include "svdm_regs.svh"
module svdm_policy_fsm
    import svdm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       roleSource,
    input  wire logic       reqModes,
    input  wire logic       reqEnter,
    input  wire logic       reqExit,
    input  wire logic       dpmAck,
    input  wire logic       modeDone,
    input  wire msg_s       rxMsg,
    input  wire logic       txDone,
    input  wire logic       cblInfoValid,
    input  wire ans_e       cblInfoAns,
    output msg_s            txMsg,
    output report_s         report,
    output logic            dpmEnterReq,
    output logic            dpmExitReq,
    output logic            cblInfoReq,
    output cmd_e            cblInfoCmd,
    output logic            hardResetSrc,
    output logic            hardResetSnk,
    output logic            readySource,
    output logic            readySink,
    output logic            cblReady
);
    // ****************************************************
    // reset release
    // ****************************************************
    logic rstMeta;
    logic rstN;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // ****************************************************
    // port initiator
    // ****************************************************
    typedef enum logic [3:0] {
        P_READY, P_MODES_REQ, P_MODES_ACK, P_MODES_NAK,
        P_ENTRY_REQ, P_ENTRY_ACK, P_ENTRY_NAK,
        P_EXIT_REQ, P_EXIT_ACK, P_HARD_RESET, P_ATTN
    } port_state_e;

    port_state_e state;
    port_state_e next_state;
    logic        roleHeld;
    result_e     outcome;
    result_e     next_outcome;
    logic        tmrStart;
    logic        tmrExpired;
    logic [11:0] tmrLoad;

    wire inReady   = (state == P_READY);
    wire rxOk      = rxMsg.valid;
    wire rxAck     = rxOk && rxMsg.ans == ANS_ACK;
    wire rxNak     = rxOk && rxMsg.ans == ANS_NAK;
    wire rxBusy    = rxOk && rxMsg.ans == ANS_BUSY;
    wire rxModes   = rxMsg.cmd == CMD_DISC_MODES;
    wire rxEnter   = rxMsg.cmd == CMD_ENTER;
    wire rxExit    = rxMsg.cmd == CMD_EXIT;
    wire rxAttn    = rxOk && rxMsg.ans == ANS_REQ && rxMsg.cmd == CMD_ATTN;
    wire rxCblId   = rxOk && rxMsg.ans == ANS_REQ
                     && rxMsg.cmd == CMD_DISC_ID;
    wire rxCblSvid = rxOk && rxMsg.ans == ANS_REQ
                     && rxMsg.cmd == CMD_DISC_SVID;
    wire rejCode   = rxNak || rxBusy;
    wire result_e  rxReject = rxNak ? RES_NAK : RES_BUSY;

    // timer restarted on the cycle each request state is entered
    assign tmrStart = inReady && (next_state != P_READY)
                      && (next_state != P_ATTN);
    assign tmrLoad  = (next_state == P_ENTRY_REQ) ? 12'(`ENTRY_CYCLES)
                    : (next_state == P_EXIT_REQ)  ? 12'(`EXIT_CYCLES)
                    : 12'(`RESP_CYCLES);

    svdm_timer u_timer (
        .clk     (clk),
        .rstN    (rstN),
        .start   (tmrStart),
        .stop    (1'b0),
        .load    (tmrLoad),
        .expired (tmrExpired)
    );

    always_comb begin
        next_state   = state;
        next_outcome = outcome;
        case (state)
            P_READY: begin
                // attention has priority since it cannot be retried
                if (rxAttn)
                    next_state = P_ATTN;
                else if (reqModes)
                    next_state = P_MODES_REQ;
                else if (reqEnter)
                    next_state = P_ENTRY_REQ;
                else if (reqExit)
                    next_state = P_EXIT_REQ;
            end
            P_MODES_REQ: begin
                if (rxAck && rxModes) begin
                    next_state   = P_MODES_ACK;
                    next_outcome = RES_ACK;
                end else if (rejCode && rxModes) begin
                    next_state   = P_MODES_NAK;
                    next_outcome = rxReject;
                end else if (tmrExpired) begin
                    next_state   = P_MODES_NAK;
                    next_outcome = RES_TIMEOUT;
                end
            end
            P_ENTRY_REQ: begin
                if (rxAck && rxEnter) begin
                    next_state   = P_ENTRY_ACK;
                    next_outcome = RES_ACK;
                end else if (rejCode && rxEnter) begin
                    next_state   = P_ENTRY_NAK;
                    next_outcome = rxReject;
                end else if (tmrExpired) begin
                    next_state   = P_ENTRY_NAK;
                    next_outcome = RES_TIMEOUT;
                end
            end
            P_EXIT_REQ: begin
                // NAK counts as acknowledged; only busy or silence resets
                if ((rxAck || rxNak) && rxExit) begin
                    next_state   = P_EXIT_ACK;
                    next_outcome = rxAck ? RES_ACK : RES_NAK;
                end else if ((rxBusy && rxExit) || tmrExpired) begin
                    next_state = P_HARD_RESET;
                end
            end
            P_MODES_ACK, P_MODES_NAK, P_ENTRY_NAK, P_ATTN: begin
                if (dpmAck)
                    next_state = P_READY;
            end
            P_ENTRY_ACK: begin
                if (dpmAck && modeDone)
                    next_state = P_READY;
            end
            P_EXIT_ACK: begin
                if (dpmAck)
                    next_state = P_READY;
            end
            P_HARD_RESET: next_state = P_HARD_RESET;
            default:      next_state = P_READY;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state    <= P_READY;
            outcome  <= RES_ACK;
            roleHeld <= 1'b0;
        end else begin
            state   <= next_state;
            outcome <= next_outcome;
            if (inReady)
                roleHeld <= roleSource;
        end
    end

    // ****************************************************
    // cable plug responder
    // ****************************************************
    typedef enum logic [2:0] {
        C_READY, C_GET_ID, C_SEND_ID, C_GET_SVID, C_SEND_SVID
    } cbl_state_e;

    cbl_state_e cstate;
    cbl_state_e next_cstate;
    ans_e       cblAns;
    logic       cblSent;

    wire cInReady = (cstate == C_READY);
    wire cGetting = (cstate == C_GET_ID) || (cstate == C_GET_SVID);
    wire cSending = (cstate == C_SEND_ID) || (cstate == C_SEND_SVID);

    always_comb begin
        next_cstate = cstate;
        case (cstate)
            C_READY: begin
                if (rxCblId)
                    next_cstate = C_GET_ID;
                else if (rxCblSvid)
                    next_cstate = C_GET_SVID;
            end
            C_GET_ID: begin
                if (cblInfoValid)
                    next_cstate = C_SEND_ID;
            end
            C_GET_SVID: begin
                if (cblInfoValid)
                    next_cstate = C_SEND_SVID;
            end
            C_SEND_ID, C_SEND_SVID: begin
                if (txDone && cblSent)
                    next_cstate = C_READY;
            end
            default: next_cstate = C_READY;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cstate  <= C_READY;
            cblAns  <= ANS_ACK;
            cblSent <= 1'b0;
        end else begin
            cstate <= next_cstate;
            if (cGetting && cblInfoValid)
                cblAns <= (cblInfoAns == ANS_REQ) ? ANS_ACK : cblInfoAns;
            // a send blocked by a port request is not counted as sent
            cblSent <= cSending && !(cblSent && txDone)
                       && (cblSent || !portEnter);
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    wire portEnter = inReady && tmrStart;
    wire cmd_e portCmd = (next_state == P_ENTRY_REQ) ? CMD_ENTER
                       : (next_state == P_EXIT_REQ)  ? CMD_EXIT
                       : CMD_DISC_MODES;
    wire cblSendNow = cSending && !cblSent;
    wire cmd_e cblCmd = (cstate == C_SEND_ID || cstate == C_GET_ID)
                        ? CMD_DISC_ID : CMD_DISC_SVID;
    wire leaving = (next_state == P_READY) && !inReady;
    wire cmd_e repCmd = (state == P_ENTRY_NAK || state == P_ENTRY_ACK)
                        ? CMD_ENTER
                      : (state == P_EXIT_ACK) ? CMD_EXIT
                      : (state == P_ATTN)     ? CMD_ATTN
                      : CMD_DISC_MODES;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            txMsg  <= '0;
            report <= '0;
        end else begin
            // port requests win the transmitter over cable answers
            if (portEnter)
                txMsg <= '{1'b1, portCmd, ANS_REQ};
            else if (cblSendNow)
                txMsg <= '{1'b1, cblCmd, cblAns};
            else
                txMsg <= '0;
            if (leaving)
                report <= '{1'b1, repCmd, outcome};
            else
                report <= '0;
        end
    end

    assign dpmEnterReq  = (state == P_ENTRY_ACK);
    assign dpmExitReq   = (state == P_EXIT_ACK);
    assign cblInfoReq   = cGetting;
    assign cblInfoCmd   = cGetting ? cblCmd : CMD_NONE;
    assign hardResetSrc = (state == P_HARD_RESET) && roleHeld;
    assign hardResetSnk = (state == P_HARD_RESET) && !roleHeld;
    assign readySource  = inReady && roleHeld;
    assign readySink    = inReady && !roleHeld;
    assign cblReady     = cInReady;

    // ****************************************************
    // checks
    // ****************************************************
    a_modes_start: assert property (@(posedge clk) disable iff (!rstN)
        inReady && !rxAttn && reqModes |=> state == P_MODES_REQ
        && txMsg.valid && txMsg.cmd == CMD_DISC_MODES)
        else $error("modes request not issued");
    a_modes_ack: assert property (@(posedge clk) disable iff (!rstN)
        state == P_MODES_REQ && rxAck && rxModes
        |=> state == P_MODES_ACK)
        else $error("modes ack not taken");
    a_modes_rej: assert property (@(posedge clk) disable iff (!rstN)
        state == P_MODES_REQ && rejCode && rxModes
        |=> state == P_MODES_NAK)
        else $error("modes reject not taken");
    a_report_out: assert property (@(posedge clk) disable iff (!rstN)
        state == P_MODES_NAK && dpmAck
        |=> report.valid && state == P_READY)
        else $error("reject outcome not reported");
    a_entry_wait: assert property (@(posedge clk) disable iff (!rstN)
        state == P_ENTRY_ACK && !modeDone
        |=> state == P_ENTRY_ACK)
        else $error("entry left before mode entered");
    a_exit_busy: assert property (@(posedge clk) disable iff (!rstN)
        state == P_EXIT_REQ && rxBusy && rxExit
        |=> hardResetSrc || hardResetSnk)
        else $error("busy exit did not hard reset");
    a_exit_nak: assert property (@(posedge clk) disable iff (!rstN)
        state == P_EXIT_REQ && rxNak && rxExit |=> dpmExitReq)
        else $error("exit nak not acknowledged");
    a_attn_note: assert property (@(posedge clk) disable iff (!rstN)
        inReady && rxAttn |=> state == P_ATTN)
        else $error("attention not noted");
    a_cbl_id: assert property (@(posedge clk) disable iff (!rstN)
        cInReady && rxCblId
        |=> cblInfoReq && cblInfoCmd == CMD_DISC_ID)
        else $error("identity not requested");
    a_cbl_send: assert property (@(posedge clk) disable iff (!rstN)
        cstate == C_GET_SVID && cblInfoValid && !portEnter
        |=> ##1 txMsg.valid && txMsg.cmd == CMD_DISC_SVID)
        else $error("svid answer not sent");
    a_role_hold: assert property (@(posedge clk) disable iff (!rstN)
        !inReady && $stable(state) |-> $stable(roleHeld))
        else $error("role changed mid exchange");

    c_modes_ok: cover property (@(posedge clk) state == P_MODES_ACK);
    c_entry_to: cover property (@(posedge clk)
        state == P_ENTRY_REQ && tmrExpired);
    c_hard_rst: cover property (@(posedge clk) state == P_HARD_RESET);
    c_cbl_done: cover property (@(posedge clk)
        cSending && txDone && cblSent);
endmodule : svdm_policy_fsm

// file: hw/svdm_regs.svh
// timing constants and timer width for the structured message sequencer
`ifndef SVDM_REGS_SVH
`define SVDM_REGS_SVH
`define CLK_PERIOD_NS       20
`define RESP_TIME_US        27
`define ENTRY_TIME_US       45
`define EXIT_TIME_US        45
`define RESP_CYCLES   ((`RESP_TIME_US * 1000) / `CLK_PERIOD_NS)
`define ENTRY_CYCLES  ((`ENTRY_TIME_US * 1000) / `CLK_PERIOD_NS)
`define EXIT_CYCLES   ((`EXIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define TMR_W               12
`endif

// file: hw/svdm_pkg.sv
// types shared by the structured message sequencer
package svdm_pkg;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_DISC_ID, CMD_DISC_SVID, CMD_DISC_MODES,
        CMD_ENTER, CMD_EXIT, CMD_ATTN
    } cmd_e;
    typedef enum logic [1:0] {ANS_ACK, ANS_NAK, ANS_BUSY, ANS_REQ} ans_e;
    typedef enum logic [1:0] {
        RES_ACK, RES_NAK, RES_BUSY, RES_TIMEOUT
    } result_e;
    typedef struct packed {
        logic valid;
        cmd_e cmd;
        ans_e ans;
    } msg_s;
    typedef struct packed {
        logic    valid;
        cmd_e    cmd;
        result_e result;
    } report_s;
endpackage : svdm_pkg

// file: hw/svdm_timer.sv
// down-counting response timer with one-cycle expiry pulse
`timescale 1ns/1ps
module svdm_timer
    import svdm_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           rstN,
    input  wire logic           start,
    input  wire logic           stop,
    input  wire logic [11:0]    load,
    output logic                expired
);
    logic [11:0] count;
    logic        running;
    wire         atOne = running && (count == 12'h0001);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            count   <= 12'h0000;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= atOne && !start && !stop;
            if (start) begin
                count   <= load;
                running <= 1'b1;
            end else if (stop || atOne) begin
                running <= 1'b0;
            end else if (running) begin
                count <= count - 12'h0001;
            end
        end
    end
endmodule : svdm_timer

// file: verif/far_partner.sv
// far-side partner model: answers port requests, completes cable sends
`timescale 1ns/1ps
module far_partner
    import svdm_pkg::*;
(
    input  wire logic       clk,
    input  wire msg_s       txMsg,
    input  wire ans_e       replyAns,
    input  wire logic [4:0] replyDelay,
    input  wire logic       silent,
    input  wire msg_s       inject,
    output msg_s            rxMsg,
    output logic            txDone
);
    // ****************************************
    // reply and send-complete sequencing
    // ****************************************
    logic [4:0] cnt;
    logic       pend;
    cmd_e       pendCmd;
    logic [1:0] doneCnt;
    logic [2:0] cyc;
    initial begin
        pend = 1'b0;
        doneCnt = 2'd0;
        cyc = 3'd0;
        cnt = 5'd0;
        pendCmd = CMD_NONE;
        rxMsg = '0;
        txDone = 1'b0;
    end
    always @(posedge clk) begin
        cyc <= cyc + 3'd1;
        // idle fields keep moving so a stale value is never mistaken
        rxMsg <= {1'b0, cmd_e'(cyc), ans_e'(~cyc[1:0])};
        txDone <= (doneCnt == 2'd1);
        if (doneCnt != 2'd0)
            doneCnt <= doneCnt - 2'd1;
        if (inject.valid)
            rxMsg <= inject;
        else if (pend && cnt == 5'd0) begin
            rxMsg <= {1'b1, pendCmd, replyAns};
            pend <= 1'b0;
        end else if (pend)
            cnt <= cnt - 5'd1;
        // silent mode lets the sender's response timer run out
        if (txMsg.valid && txMsg.ans == ANS_REQ && !silent) begin
            pend <= 1'b1;
            pendCmd <= txMsg.cmd;
            cnt <= replyDelay;
        end
        if (txMsg.valid && txMsg.ans != ANS_REQ)
            doneCnt <= 2'd2;
    end
endmodule : far_partner

// file: verif/testbench.sv
// self-checking bench for the structured message sequencer
`timescale 1ns/1ps
`include "svdm_regs.svh"
module testbench
    import svdm_pkg::*;
;
    logic clk, rst_n, roleSource, reqModes, reqEnter, reqExit;
    logic dpmAck, modeDone, txDone, cblInfoValid, silent, dpmEnterReq;
    logic dpmExitReq, cblInfoReq, hardResetSrc, hardResetSnk;
    logic readySource, readySink, cblReady;
    logic [4:0] replyDelay;
    ans_e cblInfoAns, replyAns;
    msg_s rxMsg, txMsg, inject;
    report_s report;
    cmd_e cblInfoCmd;
    int failures, testsRun;

    svdm_policy_fsm dut (.clk(clk), .rst_n(rst_n), .roleSource(roleSource),
        .reqModes(reqModes), .reqEnter(reqEnter), .reqExit(reqExit),
        .dpmAck(dpmAck), .modeDone(modeDone), .rxMsg(rxMsg), .txDone(txDone),
        .cblInfoValid(cblInfoValid), .cblInfoAns(cblInfoAns), .txMsg(txMsg),
        .report(report), .dpmEnterReq(dpmEnterReq), .dpmExitReq(dpmExitReq),
        .cblInfoReq(cblInfoReq), .cblInfoCmd(cblInfoCmd),
        .hardResetSrc(hardResetSrc), .hardResetSnk(hardResetSnk),
        .readySource(readySource), .readySink(readySink),
        .cblReady(cblReady));
    far_partner partner (.clk(clk), .txMsg(txMsg), .replyAns(replyAns),
        .replyDelay(replyDelay), .silent(silent), .inject(inject),
        .rxMsg(rxMsg), .txDone(txDone));

    // ****************************************
    // checking helpers
    // ****************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic completeRun;
        $display("comparisons %0d, failures %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : completeRun

    function automatic result_e expRes(input ans_e a, input logic sil);
        if (sil)
            return RES_TIMEOUT;
        case (a)
            ANS_NAK:  return RES_NAK;
            ANS_BUSY: return RES_BUSY;
            default:  return RES_ACK;
        endcase
    endfunction : expRes

    // ****************************************
    // exchanges
    // ****************************************
    task automatic portXchg(input cmd_e c, input ans_e a, input logic sil,
                            input logic role);
        int n, w, hi, ex, lim;
        logic early, seen;
        n = 0; w = 0; hi = 0; ex = 0; early = 0; seen = 0;
        lim = (c == CMD_DISC_MODES) ? `RESP_CYCLES
            : (c == CMD_EXIT) ? `EXIT_CYCLES : `ENTRY_CYCLES;
        @(negedge clk);
        roleSource = role;
        replyAns = a;
        silent = sil;
        dpmAck = sil;
        replyDelay = 5'($urandom_range(20));
        reqModes = (c == CMD_DISC_MODES);
        reqEnter = (c == CMD_ENTER);
        reqExit = (c == CMD_EXIT);
        while (!txMsg.valid && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({txMsg, readySource, readySink},
              {1'b1, c, ANS_REQ, 2'b00});
        reqModes = 0;
        reqEnter = 0;
        reqExit = 0;
        n = 0;
        while (!seen && n < 3000 && !(hardResetSrc | hardResetSnk)) begin
            @(negedge clk);
            n++;
            seen = report.valid;
            if (seen && !dpmAck)
                early = 1;
            if (rxMsg.valid)
                w = 1;
            else if (w != 0 && w < 4)
                w++;
            if (w == 4)
                dpmAck = 1;
            if (dpmEnterReq && !modeDone)
                hi++;
            // manager enters the mode only after the partner accepted
            if (hi == 4)
                modeDone = 1;
            if (dpmExitReq)
                ex++;
        end
        dpmAck = 0;
        modeDone = 0;
        if (c == CMD_EXIT && (sil || a == ANS_BUSY)) begin
            check({hardResetSrc, hardResetSnk}, {role, !role});
            return;
        end
        check({seen, early}, 2'b10);
        check(report,
              {1'b1, c, expRes(a, sil)});
        check(hi,
              (c == CMD_ENTER && a == ANS_ACK && !sil) ? 4 : 0);
        check(ex != 0, c == CMD_EXIT);
        if (sil)
            check(n > lim - 10 && n < lim + 10, 1);
        @(negedge clk);
        check({readySource, readySink}, {role, !role});
        $display("test %s done at %0t", c.name(), $time);
    endtask : portXchg

    task automatic cableXchg(input cmd_e c, input ans_e a);
        int n;
        n = 0;
        @(negedge clk);
        inject = {1'b1, c, ANS_REQ};
        @(negedge clk);
        inject = '0;
        while (!cblInfoReq && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({cblInfoReq, cblInfoCmd, cblReady},
              {1'b1, c, 1'b0});
        repeat ($urandom_range(3)) @(negedge clk);
        cblInfoValid = 1;
        cblInfoAns = a;
        @(negedge clk);
        cblInfoValid = 0;
        n = 0;
        while (!txMsg.valid && n < 10) begin
            @(negedge clk);
            n++;
        end
        // a manager answer of plain information is sent back as an ACK
        check({txMsg, cblReady},
              {1'b1, c, (a == ANS_REQ) ? ANS_ACK : a,
               1'b0});
        n = 0;
        while (!cblReady && n < 10) begin
            @(negedge clk);
            n++;
        end
        check(cblReady, 1);
        $display("test cable %s done at %0t", c.name(), $time);
    endtask : cableXchg

    task automatic attention(input logic role);
        int n;
        n = 0;
        @(negedge clk);
        roleSource = role;
        dpmAck = 1;
        inject = {1'b1, CMD_ATTN, ANS_REQ};
        @(negedge clk);
        inject = '0;
        while (!report.valid && n < 10) begin
            @(negedge clk);
            n++;
        end
        check({report.valid, report.cmd}, {1'b1, CMD_ATTN});
        dpmAck = 0;
        @(negedge clk);
        check({readySource, readySink}, {role, !role});
        $display("test attention done at %0t", $time);
    endtask : attention

    task automatic doReset;
        @(negedge clk);
        rst_n = 0;
        repeat (5) @(negedge clk);
        check({readySource, readySink, cblReady}, 3'b011);
        rst_n = 1;
        repeat (5) @(negedge clk);
    endtask : doReset

    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        completeRun;
    end

    initial begin
        {rst_n, roleSource, reqModes, reqEnter, reqExit, dpmAck} = '0;
        {modeDone, cblInfoValid, silent} = '0;
        {replyDelay, cblInfoAns, replyAns, inject} = '0;
        failures = 0;
        testsRun = 0;
        void'($urandom(96));
        doReset;
        portXchg(CMD_DISC_MODES, ANS_ACK, 1'b1, 1'b1);
        portXchg(CMD_ENTER, ANS_ACK, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            portXchg(CMD_DISC_MODES, ans_e'(i % 3), 1'b0, i[0]);
            portXchg(CMD_ENTER, ans_e'(i % 3), 1'b0, !i[0]);
            portXchg(CMD_EXIT, ans_e'(i % 2), 1'b0, i[1]);
            cableXchg(CMD_DISC_ID, ans_e'(i));
            cableXchg(CMD_DISC_SVID, ans_e'(3 - i));
        end
        attention(1'b1);
        attention(1'b0);
        repeat (20) begin
            case ($urandom_range(4))
                0: portXchg(CMD_DISC_MODES, ans_e'($urandom_range(2)), 1'b0,
                            1'($urandom_range(1)));
                1: portXchg(CMD_ENTER, ans_e'($urandom_range(2)), 1'b0,
                            1'($urandom_range(1)));
                2: portXchg(CMD_EXIT, ans_e'($urandom_range(1)), 1'b0,
                            1'($urandom_range(1)));
                3: cableXchg(CMD_DISC_ID, ans_e'($urandom_range(3)));
                default: cableXchg(CMD_DISC_SVID, ans_e'($urandom_range(3)));
            endcase
        end
        portXchg(CMD_EXIT, ANS_BUSY, 1'b0, 1'b1);
        doReset;
        portXchg(CMD_EXIT, ANS_ACK, 1'b1, 1'b0);
        doReset;
        completeRun;
    end
endmodule : testbench
